// file: pkg/ppwel_pkg.sv
// Package of the posted-write error log: register map, fields, carriers.
// Assumes a 32-bit classic Wishbone register bus and a same-clock PCI master.
package ppwel_pkg;

	// Register byte offsets.
	localparam logic [11:0] OFS_CTL = 12'h140;
	localparam logic [11:0] OFS_ADDR = 12'h144;
	localparam logic [11:0] OFS_DATA = 12'h148;
	localparam logic [11:0] OFS_ISTS = 12'h14c;
	localparam logic [11:0] OFS_IMSK = 12'h150;

	// Field positions in the control and status word.
	localparam int BIT_EN = 31;
	localparam int BIT_ES = 24;
	localparam int BIT_UNL = 23;
	localparam int POS_CMD = 4;
	localparam int POS_BE = 0;

	// Reset and initial values.
	localparam logic RST_EN = 1'b0;
	localparam logic RST_UNL = 1'b0;
	localparam logic RST_ES = 1'b0;
	localparam logic [3:0] INIT_CMD = 4'h7;
	localparam logic [3:0] RST_BE = 4'h0;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// Interrupt events.
	localparam int NUM_EVT = 2;
	localparam int EVT_LOGGED = 0;
	localparam int EVT_DROPPED = 1;
	localparam logic [NUM_EVT-1:0] RST_IRQ = 2'h0;

	// PCI commands that may be posted: memory write and its invalidate form.
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;

	// Wishbone request as seen by the slave.
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [11:0] adr;
		logic [31:0] dat;
	} ppwel_wb_req_t;

	// End of a posted write on PCI, as reported by the master logic.
	typedef struct packed {
		logic done;
		logic posted;
		logic target_abort;
		logic master_abort;
		logic [3:0] cmd;
		logic [3:0] be_n;
		logic [31:0] addr;
		logic [31:0] data;
	} ppwel_pm_evt_t;

	// Contents of the error log.
	typedef struct packed {
		logic es;
		logic [3:0] cmd;
		logic [3:0] be;
		logic [31:0] addr;
		logic [31:0] data;
	} ppwel_log_t;

endpackage

// file: design/ppwel_capture.sv
// Error log capture: freezes one failed posted write until cleared.
// Assumes the event input is synchronous to clk_i and valid for one cycle.
`timescale 1ns/1ps
module ppwel_capture (
	// Clock, reset, enable.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Control.
	input wire logic en_i,
	input wire logic clr_i,
	input wire ppwel_pkg::ppwel_pm_evt_t evt_i,
	// Results.
	output ppwel_pkg::ppwel_log_t log_o,
	output logic logged_o,
	output logic dropped_o
);
	ppwel_pkg::ppwel_log_t log_q = '{es: ppwel_pkg::RST_ES,
		cmd: ppwel_pkg::INIT_CMD, be: ppwel_pkg::RST_BE,
		addr: ppwel_pkg::RST_WORD, data: ppwel_pkg::RST_WORD};
	ppwel_pkg::ppwel_log_t log_d;
	logic failed;
	logic mem_wr;
	logic take;

	// Decide whether an abort is logged; a clear in the same cycle reopens
	// the log so that the new error is not lost.
	always_comb begin
		mem_wr = (evt_i.cmd == ppwel_pkg::CMD_MEM_WR) ||
			(evt_i.cmd == ppwel_pkg::CMD_MEM_WR_INV);
		failed = evt_i.done && evt_i.posted && mem_wr &&
			(evt_i.target_abort || evt_i.master_abort);
		take = failed && en_i && (!log_q.es || clr_i);
		log_d = log_q;
		if (clr_i) begin
			log_d.es = 1'b0;
		end
		if (take) begin
			log_d.es = 1'b1;
			log_d.cmd = evt_i.cmd;
			log_d.be = evt_i.be_n;
			log_d.addr = evt_i.addr;
			log_d.data = evt_i.data;
		end
		logged_o = take;
		dropped_o = failed && !take;
	end

	// Log register; the command field keeps its value across reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			log_q.es <= ppwel_pkg::RST_ES;
			log_q.be <= ppwel_pkg::RST_BE;
			log_q.addr <= ppwel_pkg::RST_WORD;
			log_q.data <= ppwel_pkg::RST_WORD;
		end else if (ce_i) begin
			log_q <= log_d;
		end
	end

	assign log_o = log_q;
endmodule

// file: design/ppwel_irq.sv
// Sticky interrupt status with write-one-to-clear and a mask of one layout.
// Assumes event pulses and register writes are synchronous to clk_i.
`timescale 1ns/1ps
module ppwel_irq #(
	parameter int N = 2
) (
	// Clock, reset, enable.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Events and software access.
	input wire logic [N-1:0] evt_i,
	input wire logic [N-1:0] gate_i,
	input wire logic sts_wr_i,
	input wire logic msk_wr_i,
	input wire logic [N-1:0] wdat_i,
	// State.
	output logic [N-1:0] sts_o,
	output logic [N-1:0] msk_o,
	output logic irq_o
);
	typedef struct packed {
		logic [N-1:0] sts;
		logic [N-1:0] msk;
		logic irq;
	} ppwel_irq_state_t;

	ppwel_irq_state_t s_q;
	ppwel_irq_state_t s_d;
	logic [N-1:0] clr;

	// A new event wins over a clear written in the same cycle.
	always_comb begin
		clr = sts_wr_i ? wdat_i : '0;
		s_d = s_q;
		s_d.sts = (s_q.sts & ~clr) | evt_i;
		if (msk_wr_i) begin
			s_d.msk = wdat_i;
		end
		s_d.irq = |(s_d.sts & s_d.msk & gate_i);
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign sts_o = s_q.sts;
	assign msk_o = s_q.msk;
	assign irq_o = s_q.irq;
endmodule

// file: design/ppwel_top.sv
// Posted-write error log register bank with a classic Wishbone slave.
// Assumes the PCI master logic and the bus share clk_i; no crossing.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module ppwel_top (
	// Clock, reset, enable.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave.
	input wire ppwel_pkg::ppwel_wb_req_t wb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// PCI master completion reports.
	input wire ppwel_pkg::ppwel_pm_evt_t pm_i,
	// Status to the bridge.
	output logic suspend_o,
	output logic es_int_o,
	output logic irq_o
);
	// Control state of the register bank.
	typedef struct packed {
		logic en;
		logic unl;
		logic ack;
		logic [31:0] rdat;
		logic suspend;
		logic es_int;
	} ppwel_top_state_t;

	ppwel_top_state_t s_q;
	ppwel_top_state_t s_d;
	ppwel_pkg::ppwel_log_t log;
	logic req;
	logic wr;
	logic hit_ctl;
	logic hit_ists;
	logic hit_imsk;
	logic es_clr;
	logic logged;
	logic dropped;
	logic [ppwel_pkg::NUM_EVT-1:0] evts;
	logic [ppwel_pkg::NUM_EVT-1:0] gate;
	logic [ppwel_pkg::NUM_EVT-1:0] ists;
	logic [ppwel_pkg::NUM_EVT-1:0] imsk;
	logic irq;
	logic [31:0] ctl_word;

	// Address decode; a new request is taken once per ack.
	always_comb begin
		req = wb_i.cyc && wb_i.stb && !s_q.ack;
		wr = req && wb_i.we;
		hit_ctl = wb_i.adr == ppwel_pkg::OFS_CTL;
		hit_ists = wb_i.adr == ppwel_pkg::OFS_ISTS;
		hit_imsk = wb_i.adr == ppwel_pkg::OFS_IMSK;
		es_clr = wr && hit_ctl && wb_i.sel[3] &&
			wb_i.dat[ppwel_pkg::BIT_ES];
	end

	// Log capture and freeze.
	ppwel_capture u_capture (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.en_i(s_q.en),
		.clr_i(es_clr),
		.evt_i(pm_i),
		.log_o(log),
		.logged_o(logged),
		.dropped_o(dropped)
	);

	// Interrupt events; the logged event is gated by the enable bit.
	always_comb begin
		evts = '0;
		evts[ppwel_pkg::EVT_LOGGED] = logged;
		evts[ppwel_pkg::EVT_DROPPED] = dropped;
		gate = '1;
		gate[ppwel_pkg::EVT_LOGGED] = s_d.en;
	end

	// Sticky interrupt status and mask.
	ppwel_irq #(
		.N(ppwel_pkg::NUM_EVT)
	) u_irq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.evt_i(evts),
		.gate_i(gate),
		.sts_wr_i(wr && hit_ists && wb_i.sel[0]),
		.msk_wr_i(wr && hit_imsk && wb_i.sel[0]),
		.wdat_i(wb_i.dat[ppwel_pkg::NUM_EVT-1:0]),
		.sts_o(ists),
		.msk_o(imsk),
		.irq_o(irq)
	);

	// Control and status word; logged byte enables read zero with flag clear, the command field does not.
	always_comb begin
		ctl_word = '0;
		ctl_word[ppwel_pkg::BIT_EN] = s_q.en;
		ctl_word[ppwel_pkg::BIT_ES] = log.es;
		ctl_word[ppwel_pkg::BIT_UNL] = s_q.unl;
		ctl_word[ppwel_pkg::POS_CMD +: 4] = log.cmd;
		ctl_word[ppwel_pkg::POS_BE +: 4] =
			log.es ? log.be : '0;
	end

	// Next state: register writes, read data, ack and status outputs.
	always_comb begin
		s_d = s_q;
		s_d.ack = req;
		if (wr && hit_ctl && wb_i.sel[3]) begin
			s_d.en = wb_i.dat[ppwel_pkg::BIT_EN];
		end
		if (wr && hit_ctl && wb_i.sel[2]) begin
			s_d.unl = wb_i.dat[ppwel_pkg::BIT_UNL];
		end
		if (req && !wb_i.we) begin
			case (wb_i.adr)
				ppwel_pkg::OFS_CTL: begin
					s_d.rdat = ctl_word;
				end
				ppwel_pkg::OFS_ADDR: begin
					s_d.rdat = log.es ? log.addr : '0;
				end
				ppwel_pkg::OFS_DATA: begin
					s_d.rdat = log.es ? log.data : '0;
				end
				ppwel_pkg::OFS_ISTS: begin
					s_d.rdat = {30'h0, ists};
				end
				ppwel_pkg::OFS_IMSK: begin
					s_d.rdat = {30'h0, imsk};
				end
				default: begin
					s_d.rdat = '0;
				end
			endcase
		end
		// Flag value one cycle ahead, so outputs follow it without lag, except a clear and a new error in one cycle lag by one cycle.
		s_d.suspend = (log.es || logged) && !es_clr && !s_d.unl;
		s_d.es_int = (log.es || logged) && !es_clr && s_d.en;
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q.en <= ppwel_pkg::RST_EN;
			s_q.unl <= ppwel_pkg::RST_UNL;
			s_q.ack <= 1'b0;
			s_q.rdat <= ppwel_pkg::RST_WORD;
			s_q.suspend <= 1'b0;
			s_q.es_int <= 1'b0;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign wb_dat_o = s_q.rdat;
	assign wb_ack_o = s_q.ack;
	assign suspend_o = s_q.suspend;
	assign es_int_o = s_q.es_int;
	assign irq_o = irq;
endmodule

// file: dv/ppwel_top_sva.sv
// Checker of the error log bank, bound to its top module.
// Assumes software never turns logging off while the flag is set.
`timescale 1ns/1ps
module ppwel_top_sva (
	// Clock, reset, enable.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Bus and events.
	input wire ppwel_pkg::ppwel_wb_req_t wb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire ppwel_pkg::ppwel_pm_evt_t pm_i,
	// Status.
	input wire logic suspend_o,
	input wire logic es_int_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Taken request, and a read with no error held and no event.
	wire logic rq = wb_i.cyc & wb_i.stb & ~wb_ack_o & ce_i;
	wire logic rd0 = rq & ~wb_i.we & ~es_int_o & ~pm_i.done;
	wire logic ab = pm_i.target_abort | pm_i.master_abort;
	AST_ACK_NEXT: assert property (rq |=> wb_ack_o) else $error("no ack");
	AST_ACK_PULSE: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("long ack");
	AST_CAUSE: assert property (
		$rose(es_int_o) |-> $past(pm_i.done && pm_i.posted && ab))
		else $error("flag without abort");
	AST_MEM_ONLY: assert property (
		pm_i.done && !(pm_i.cmd inside {4'h7, 4'hf}) && !rq
		|=> !$rose(es_int_o)) else $error("non-memory logged");
	AST_SUSP: assert property (suspend_o |-> es_int_o)
		else $error("suspend without flag");
	AST_W1C: assert property (
		rq && wb_i.we && wb_i.adr == ppwel_pkg::OFS_CTL && wb_i.sel[3]
		&& wb_i.dat[24] && !pm_i.done |=> !es_int_o && !suspend_o)
		else $error("flag not cleared");
	AST_ADDR_ZERO: assert property (
		rd0 && wb_i.adr == ppwel_pkg::OFS_ADDR |=> wb_dat_o == 32'h0)
		else $error("address log not zero");
	AST_DATA_ZERO: assert property (
		rd0 && wb_i.adr == ppwel_pkg::OFS_DATA |=> wb_dat_o == 32'h0)
		else $error("data log not zero");
	AST_LANE_ZERO: assert property (
		rd0 && wb_i.adr == ppwel_pkg::OFS_CTL |=> wb_dat_o[3:0] == 4'h0)
		else $error("lane log not zero");
	// Main scenarios reached.
	cover property ($rose(suspend_o));
	cover property ($rose(es_int_o) && !suspend_o);
	cover property ($rose(irq_o));
endmodule
bind ppwel_top ppwel_top_sva chk_u (.clk_i(clk_i), .rst_i(rst_i),
	.ce_i(ce_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.pm_i(pm_i), .suspend_o(suspend_o), .es_int_o(es_int_o),
	.irq_o(irq_o));

// file: dv/ppwel_pci_tgt.sv
// Far-side model: a PCI target ending each posted write it is handed.
// Assumes the bench gives a whole completion report with go_i.
`timescale 1ns/1ps
module ppwel_pci_tgt (
	// Clock and the write to end.
	input wire logic clk_i,
	input wire logic go_i,
	input wire ppwel_pkg::ppwel_pm_evt_t ev_i,
	// Completion report.
	output ppwel_pkg::ppwel_pm_evt_t pm_o
);
	// Report lasts one cycle; idle lines toggle so stale values never hold.
	initial pm_o = '0;
	// The done bit is the top field, so it is forced low between reports.
	always @(posedge clk_i) begin
		pm_o <= go_i ? ev_i : {1'b0, ~pm_o[$bits(pm_o)-2:0]};
	end
endmodule

// file: dv/ppwel_top_tb_top.sv
// Testbench of the error log bank: bus accesses and aborted writes.
// Assumes the target model reports one write per go pulse.
`timescale 1ns/1ps
module ppwel_top_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic go = 1'b0;
	logic ack, susp, es_int, irq;
	logic [31:0] dat;
	logic [31:0] r;
	int mismatches = 0;
	int num_checks = 0;
	ppwel_pkg::ppwel_wb_req_t req = '0;
	ppwel_pkg::ppwel_pm_evt_t ev = '0;
	ppwel_pkg::ppwel_pm_evt_t pm;
	ppwel_pci_tgt tgt_u (.clk_i(clk_i), .go_i(go), .ev_i(ev), .pm_o(pm));
	ppwel_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_i(req),
		.wb_dat_o(dat), .wb_ack_o(ack), .pm_i(pm), .suspend_o(susp),
		.es_int_o(es_int), .irq_o(irq));
	// Clock of 4 ns.
	initial forever #2 clk_i = ~clk_i;
	// Prints the counts and the verdict, then stops.
	task complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Compares a value with its expectation.
	task ck(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One classic Wishbone access; read data is taken at the ack edge.
	task wb(input logic we, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req <= {2'h3, we, 4'hf, a, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t no ack", $time);
		end
		r = dat;
		req <= '0;
		@(posedge clk_i);
	endtask
	// Reads a register and compares it.
	task rc(input logic [11:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		ck(r, e);
	endtask
	// Has the target end one posted write, then lets the log settle.
	task pw(input logic [1:0] k, input logic [3:0] c, input logic [31:0] a);
		ev <= {2'h3, k, c, 4'h5, a, ~a};
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	// Main sequence.
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rc(12'h140, 32'h0000_0070);
		rc(12'h144, 32'h0);
		pw(2'h2, 4'h7, 32'h1234_5678);
		rc(12'h140, 32'h0000_0070);
		wb(1'b1, 12'h150, 32'h1);
		wb(1'b1, 12'h140, 32'h8000_0000);
		pw(2'h2, 4'h7, 32'h1234_5678);
		ck({30'h0, susp, irq}, 32'h3);
		rc(12'h140, 32'h8100_0075);
		rc(12'h148, 32'hedcb_a987);
		pw(2'h1, 4'hf, 32'h0000_abc0);
		rc(12'h144, 32'h1234_5678);
		wb(1'b1, 12'h140, 32'h8080_0000);
		ck({30'h0, susp, es_int}, 32'h1);
		rc(12'h140, 32'h8180_0075);
		rc(12'h14c, 32'h3);
		wb(1'b1, 12'h14c, 32'h3);
		rc(12'h14c, 32'h0);
		rc(12'h150, 32'h1);
		wb(1'b1, 12'h140, 32'h8180_0000);
		ck({30'h0, irq, es_int}, 32'h0);
		rc(12'h148, 32'h0);
		rc(12'h140, 32'h8080_0070);
		pw(2'h2, 4'h3, 32'h5555_0000);
		rc(12'h144, 32'h0);
		wb(1'b1, 12'h150, 32'h0);
		pw(2'h1, 4'hf, 32'h0000_abc0);
		ck({30'h0, irq, es_int}, 32'h1);
		rc(12'h144, 32'h0000_abc0);
		wb(1'b1, 12'h140, 32'h0100_0000);
		rc(12'h140, 32'h0000_00f0);
		rc(12'h1fc, 32'h0);
		complete_run();
	end
	// Cuts a hung run short.
	initial begin
		#20000;
		mismatches++;
		complete_run();
	end
endmodule
